/* File: hw/mag_cfg.svh */
// Register offsets, field positions, reset values and timing counts of the mode and status bank.
// Behaviour
// - Status bits: overrun, overflow, high zyx, low zyx.
// - Power control stays accessible during suspend.
// - Soft reset needs both trigger bits in one write.
// - Soft reset defaults all but power control.
// - Soft reset always ends in sleep mode.
// - Soft reset ignored while suspended.
// - Trigger bits self-clear after soft reset.
// - Suspend then sleep gives full power-on reset.
// - Bit 2 selects three-wire serial, default four-wire.
// - Bit 0 one wakes to sleep, zero suspends.
// - Operation register: selftest, rate, mode, normal selftest.
// - Rate codes map to 10,2,6,8,15,20,25,30 Hz.
// - Mode codes: normal, forced, sleep.
// - Advanced selftest field separate from normal selftest.
// - Latched flags hold until status register read.
// - Overrun flag shown only when its enable set.
`ifndef MAG_CFG_SVH
`define MAG_CFG_SVH

`define REG_IRQ_FLAGS   8'h4a
`define REG_PWR_CTRL    8'h4b
`define REG_OP_CTRL     8'h4c
`define REG_IRQ_EN      8'h4d
`define REG_IRQ_PIN     8'h4e

`define PWR_SRST_HI     7
`define PWR_SPI3        2
`define PWR_SRST_LO     1
`define PWR_ON          0

`define IRQ_OVR_EN      7
`define IRQ_OVF_EN      6
`define PIN_INT_EN      6
`define PIN_LATCH       1
`define PIN_POL         0

`define OP_DEFAULT      8'h06
`define IRQ_EN_DEFAULT  8'h3f
`define IRQ_PIN_DEFAULT 8'h07

`define CLK_MHZ         250
`define SRST_TIME_NS    1000
`define SRST_CYCLES     ((`SRST_TIME_NS * `CLK_MHZ + 999) / 1000)

`endif

/* File: hw/mag_pkg.sv */
// Types shared by the mode and status bank.
package mag_pkg;

  // Soft reset sequencer states, one-hot.
  typedef enum logic [1:0] {
    SR_IDLE = 2'b01,
    SR_BUSY = 2'b10
  } srst_state_e;

  // Operation mode codes.
  typedef enum logic [1:0] {
    OPM_NORMAL   = 2'b00,
    OPM_FORCED   = 2'b01,
    OPM_RESERVED = 2'b10,
    OPM_SLEEP    = 2'b11
  } opmode_e;

  // Output rate codes for the measurement engine.
  typedef enum logic [2:0] {
    RATE_10HZ = 3'h0,
    RATE_2HZ  = 3'h1,
    RATE_6HZ  = 3'h2,
    RATE_8HZ  = 3'h3,
    RATE_15HZ = 3'h4,
    RATE_20HZ = 3'h5,
    RATE_25HZ = 3'h6,
    RATE_30HZ = 3'h7
  } measurement_rate_hz_e;

endpackage : mag_pkg

/* File: hw/flag_if.sv */
// Carrier between the register bank and its interrupt flag store.
`timescale 1ns/1ns
interface flag_if;
  logic [7:0] live;        // Live conditions, overrun down to low x.
  logic       overrun_en;  // Overrun indication enable.
  logic [5:0] axis_dis;    // Active-high threshold axis disables.
  logic       ovf_pin_en;  // Overflow routed to the pin.
  logic       latch;       // Latched flag mode.
  logic       rd_clr;      // Status register read this cycle.
  logic       clr_all;     // Held clear by suspend or soft reset.
  logic [7:0] status;      // Flag register contents.
  logic       pin_any;     // Some axis flag, or overflow if routed to the pin, is up; overrun never counts.

  modport bank (input live, overrun_en, axis_dis, ovf_pin_en, latch, rd_clr, clr_all,
                output status, pin_any);
  modport ctrl (output live, overrun_en, axis_dis, ovf_pin_en, latch, rd_clr, clr_all,
                input status, pin_any);
endinterface : flag_if

/* File: hw/flag_bank.sv */
// Interrupt status flag store with latched and live modes.
`timescale 1ns/1ns
`include "mag_cfg.svh"
module flag_bank
(
  input wire logic clk,    // Block clock.
  input wire logic rst_n,  // Asynchronous reset, active low.
  flag_if.bank     fl      // Flag controls and status.
);
  import mag_pkg::*;

  logic [7:0] flags_q;  // Stored flags.
  logic [7:0] flags_d;  // Next flags.
  logic [7:0] mask;     // Which live conditions may show.

  // Next flag value; a new event beats a clearing read in the same cycle.
  always_comb
  begin
    mask    = {fl.overrun_en, 1'b1, ~fl.axis_dis};
    flags_d = fl.live & mask;
    if (fl.clr_all)
    begin
      flags_d = 8'h00;
    end
    else if (fl.latch && !fl.rd_clr)
    begin
      flags_d = flags_d | (flags_q & mask);
    end
  end

  // Flag register.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      flags_q <= 8'h00;
    end
    else
    begin
      flags_q <= flags_d;
    end
  end

  assign fl.status  = flags_q;
  assign fl.pin_any = |(flags_q & {1'b0, fl.ovf_pin_en, 6'h3f});

  AST_OVERRUN_GATED: assert property (@(posedge clk) disable iff (!rst_n)
    !fl.overrun_en |=> !fl.status[7])
    else $error("Overrun flag shown while disabled.");

  AST_LATCH_HOLDS: assert property (@(posedge clk) disable iff (!rst_n)
    (fl.latch && fl.status[6] && !fl.rd_clr && !fl.clr_all) |=> fl.status[6])
    else $error("Latched overflow flag dropped without a read.");

  AST_SET_WINS: assert property (@(posedge clk) disable iff (!rst_n)
    (fl.rd_clr && fl.live[6] && !fl.clr_all) |=> fl.status[6])
    else $error("Event lost against a clearing read.");

endmodule : flag_bank

/* File: hw/mode_status_regs.sv */
// Mode, power and interrupt status register bank with soft reset sequencer.
`timescale 1ns/1ns
`include "mag_cfg.svh"
module mode_status_regs
#(
  parameter int SRST_CYCLES = `SRST_CYCLES  // Soft reset duration in clocks.
)
(
  input  wire logic                          REF_CLK,         // 250 MHz clock.
  input  wire logic                          NRST,            // Async reset, active low.
  input  wire logic                          REG_WR,          // Write strobe, one cycle.
  input  wire logic                          REG_RD,          // Read strobe, one cycle.
  input  wire logic [7:0]                    REG_ADDR,        // Register address.
  input  wire logic [7:0]                    REG_WDATA,       // Write data.
  input  wire logic [7:0]                    EVT_LIVE,        // Live interrupt conditions.
  output logic      [7:0]                    REG_RDATA,       // Read data.
  output logic                               REG_RVALID,      // Read data valid pulse.
  output logic                               INT_OUT,         // Interrupt pin level.
  output logic                               THREE_WIRE_SELECT, // Serial three-wire mode.
  output logic                               SUSPEND,         // Device in suspend.
  output logic                               SRST_BUSY,       // Soft reset running.
  output mag_pkg::opmode_e                   OP_MODE,         // Operation mode.
  output mag_pkg::measurement_rate_hz_e      MEASUREMENT_RATE_HZ, // Output rate code.
  output logic      [1:0]                    ADVANCED_SELFTEST_FIELD, // Advanced self-test.
  output logic                               NORMAL_SELFTEST  // Normal self-test.
);
  import mag_pkg::*;

  // True when the current access addresses the given register.
  function automatic logic is_addr(input logic [7:0] a, input logic [7:0] target);
    is_addr = (a == target);
  endfunction : is_addr

  flag_if fl ();  // Link to the flag store.

  srst_state_e sr_state_q;  // Soft reset sequencer state.
  srst_state_e sr_state_d;  // Next sequencer state.
  logic [8:0]  sr_cnt_q;    // Cycles left in soft reset.
  logic [8:0]  sr_cnt_d;    // Next count.
  logic        pwr_q;       // Power bit, zero is suspend.
  logic        pwr_d;       // Next power bit.
  logic        spi3_q;      // Three-wire select.
  logic        spi3_d;      // Next three-wire select.
  logic [7:0]  op_q;        // Operation register.
  logic [7:0]  op_d;        // Next operation register.
  logic [7:0]  irq_en_q;    // Interrupt enable register.
  logic [7:0]  irq_en_d;    // Next interrupt enable register.
  logic [7:0]  irq_pin_q;   // Pin and latch settings register.
  logic [7:0]  irq_pin_d;   // Next pin settings.
  logic [7:0]  rdata_q;     // Read data register.
  logic [7:0]  rdata_d;     // Next read data.
  logic        rvalid_q;    // Read valid register.
  logic        int_q;       // Interrupt pin register.
  logic        int_d;       // Next interrupt pin level.
  logic        busy;        // Soft reset in progress.
  logic        wr_pwr;      // Write to power control.
  logic        sr_start;    // Soft reset accepted this cycle.
  logic        hold_dflt;   // Other registers held at defaults.

  assign busy      = (sr_state_q == SR_BUSY);
  assign wr_pwr    = REG_WR && is_addr(REG_ADDR, `REG_PWR_CTRL);
  // Suspend keeps all but power control at power-on values, so waking is a full reset.
  assign hold_dflt = !pwr_q || busy;
  // Both triggers in one write, awake, and no reset already running.
  assign sr_start  = wr_pwr && REG_WDATA[`PWR_SRST_HI] && REG_WDATA[`PWR_SRST_LO]
                     && pwr_q && !busy;

  // Soft reset sequencer next state.
  always_comb
  begin
    sr_state_d = sr_state_q;
    sr_cnt_d   = sr_cnt_q;
    case (sr_state_q)
      SR_IDLE:
      begin
        if (sr_start)
        begin
          sr_state_d = SR_BUSY;
          sr_cnt_d   = 9'(SRST_CYCLES - 1);
        end
      end
      SR_BUSY:
      begin
        // Ending the reset drops the trigger bits without a host write.
        if (sr_cnt_q == 9'h000)
        begin
          sr_state_d = SR_IDLE;
        end
        else
        begin
          sr_cnt_d = sr_cnt_q - 9'h001;
        end
      end
      default:
      begin
        sr_state_d = SR_IDLE;
        sr_cnt_d   = 9'h000;
      end
    endcase
  end

  // Soft reset sequencer registers.
  always_ff @(posedge REF_CLK or negedge NRST)
  begin
    if (!NRST)
    begin
      sr_state_q <= SR_IDLE;
      sr_cnt_q   <= 9'h000;
    end
    else
    begin
      sr_state_q <= sr_state_d;
      sr_cnt_q   <= sr_cnt_d;
    end
  end

  // Next register contents. Power control is written in any mode; the rest
  // only while awake and outside a soft reset.
  always_comb
  begin
    pwr_d     = pwr_q;
    spi3_d    = spi3_q;
    op_d      = op_q;
    irq_en_d  = irq_en_q;
    irq_pin_d = irq_pin_q;
    if (wr_pwr)
    begin
      pwr_d  = REG_WDATA[`PWR_ON];
      spi3_d = REG_WDATA[`PWR_SPI3];
    end
    if (hold_dflt)
    begin
      // Default operation register selects sleep mode.
      op_d      = `OP_DEFAULT;
      irq_en_d  = `IRQ_EN_DEFAULT;
      irq_pin_d = `IRQ_PIN_DEFAULT;
    end
    else if (REG_WR)
    begin
      // Reserved mode code is stored as written; keeping it out is the host's job.
      if (is_addr(REG_ADDR, `REG_OP_CTRL))
      begin
        op_d = REG_WDATA;
      end
      if (is_addr(REG_ADDR, `REG_IRQ_EN))
      begin
        irq_en_d = REG_WDATA;
      end
      if (is_addr(REG_ADDR, `REG_IRQ_PIN))
      begin
        irq_pin_d = REG_WDATA;
      end
    end
  end

  // Control registers; the device leaves reset suspended.
  always_ff @(posedge REF_CLK or negedge NRST)
  begin
    if (!NRST)
    begin
      pwr_q     <= 1'b0;
      spi3_q    <= 1'b0;
      op_q      <= `OP_DEFAULT;
      irq_en_q  <= `IRQ_EN_DEFAULT;
      irq_pin_q <= `IRQ_PIN_DEFAULT;
    end
    else
    begin
      pwr_q     <= pwr_d;
      spi3_q    <= spi3_d;
      op_q      <= op_d;
      irq_en_q  <= irq_en_d;
      irq_pin_q <= irq_pin_d;
    end
  end

  // Flag store hookup; the live vector is already in status bit order.
  assign fl.live       = EVT_LIVE;
  assign fl.overrun_en = irq_en_q[`IRQ_OVR_EN];
  assign fl.axis_dis   = irq_en_q[5:0];
  assign fl.ovf_pin_en = irq_en_q[`IRQ_OVF_EN];
  assign fl.latch      = irq_pin_q[`PIN_LATCH];
  assign fl.rd_clr     = REG_RD && is_addr(REG_ADDR, `REG_IRQ_FLAGS) && !hold_dflt;
  assign fl.clr_all    = hold_dflt;

  flag_bank u_flags (
    .clk   (REF_CLK),
    .rst_n (NRST),
    .fl    (fl)
  );

  // Read mux and pin level. Other registers read zero while suspended.
  always_comb
  begin
    rdata_d = 8'h00;
    case (REG_ADDR)
      `REG_IRQ_FLAGS: rdata_d = hold_dflt ? 8'h00 : fl.status;
      // Trigger bits read as one only while the reset runs; 6..3 are zero.
      `REG_PWR_CTRL:  rdata_d = {busy, 4'h0, spi3_q, busy, pwr_q};
      `REG_OP_CTRL:   rdata_d = hold_dflt ? 8'h00 : op_q;
      `REG_IRQ_EN:    rdata_d = hold_dflt ? 8'h00 : irq_en_q;
      `REG_IRQ_PIN:   rdata_d = hold_dflt ? 8'h00 : irq_pin_q;
      default:        rdata_d = 8'h00;
    endcase
    // Inactive pin sits at the opposite of the chosen polarity.
    int_d = (irq_pin_q[`PIN_INT_EN] && fl.pin_any) ? irq_pin_q[`PIN_POL]
                                                    : !irq_pin_q[`PIN_POL];
  end

  // Read port and pin registers.
  always_ff @(posedge REF_CLK or negedge NRST)
  begin
    if (!NRST)
    begin
      rdata_q  <= 8'h00;
      rvalid_q <= 1'b0;
      int_q    <= 1'b0;
    end
    else
    begin
      rdata_q  <= REG_RD ? rdata_d : rdata_q;
      rvalid_q <= REG_RD;
      int_q    <= int_d;
    end
  end

  assign REG_RDATA               = rdata_q;
  assign REG_RVALID              = rvalid_q;
  assign INT_OUT                 = int_q;
  assign THREE_WIRE_SELECT       = spi3_q;
  assign SUSPEND                 = !pwr_q;
  assign SRST_BUSY               = busy;
  assign OP_MODE                 = opmode_e'(op_q[2:1]);
  assign MEASUREMENT_RATE_HZ     = measurement_rate_hz_e'(op_q[5:3]);
  assign ADVANCED_SELFTEST_FIELD = op_q[7:6];
  assign NORMAL_SELFTEST         = op_q[0];

  AST_SR_STARTS: assert property (@(posedge REF_CLK) disable iff (!NRST)
    sr_start |=> busy [*2])
    else $error("Soft reset did not start on a double trigger write.");

  AST_SR_ONE_TRIGGER: assert property (@(posedge REF_CLK) disable iff (!NRST)
    (wr_pwr && (REG_WDATA[`PWR_SRST_HI] != REG_WDATA[`PWR_SRST_LO]) && !busy) |=> !busy)
    else $error("Soft reset started from a single trigger bit.");

  AST_SR_SUSPENDED: assert property (@(posedge REF_CLK) disable iff (!NRST)
    (wr_pwr && !pwr_q && !busy) |=> !busy && (op_q == `OP_DEFAULT))
    else $error("Soft reset accepted while suspended.");

  AST_SR_ENDS_SLEEP: assert property (@(posedge REF_CLK) disable iff (!NRST)
    (busy && sr_cnt_q == 9'h000)
      |=> !busy && (OP_MODE == OPM_SLEEP) && (irq_en_q == `IRQ_EN_DEFAULT))
    else $error("Soft reset did not end in sleep with defaults.");

  AST_SR_SELFCLEAR: assert property (@(posedge REF_CLK) disable iff (!NRST)
    (REG_RD && is_addr(REG_ADDR, `REG_PWR_CTRL) && !busy) |=> !REG_RDATA[7] && !REG_RDATA[1])
    else $error("Trigger bits read back set outside a soft reset.");

  AST_PWR_ZERO_BITS: assert property (@(posedge REF_CLK) disable iff (!NRST)
    (REG_RD && is_addr(REG_ADDR, `REG_PWR_CTRL)) |=> REG_RVALID && (REG_RDATA[6:3] == 4'h0))
    else $error("Power control bits 6..3 read nonzero.");

  AST_PWR_WRITE: assert property (@(posedge REF_CLK) disable iff (!NRST)
    wr_pwr |=> (SUSPEND == !$past(REG_WDATA[0])) && (THREE_WIRE_SELECT == $past(REG_WDATA[2])))
    else $error("Power or wire select not taken from the write.");

  AST_SUSPEND_DEFAULTS: assert property (@(posedge REF_CLK) disable iff (!NRST)
    (!pwr_q && !REG_WR) |=> (op_q == `OP_DEFAULT) && (fl.status == 8'h00))
    else $error("Registers not at power-on values in suspend.");

  AST_OP_FIELDS: assert property (@(posedge REF_CLK) disable iff (!NRST)
    (REG_WR && is_addr(REG_ADDR, `REG_OP_CTRL) && !hold_dflt)
      |=> (ADVANCED_SELFTEST_FIELD == $past(REG_WDATA[7:6]))
          && (MEASUREMENT_RATE_HZ == $past(REG_WDATA[5:3]))
          && (NORMAL_SELFTEST == $past(REG_WDATA[0])))
    else $error("Operation register fields misplaced.");

endmodule : mode_status_regs

/* File: verif/host_model.sv */
// Host processor model that reaches the bank through its strobe port.
`timescale 1ns/1ns
`include "mag_cfg.svh"
module host_model
(
  input  wire logic       clk,    // Block clock.
  output logic            wr,     // Write strobe.
  output logic            rd,     // Read strobe.
  output logic      [7:0] addr,   // Register address.
  output logic      [7:0] wdata,  // Write data.
  input  wire logic [7:0] rdata,  // Read data.
  input  wire logic       rvalid  // Read data valid.
);
  // Strobes idle low from time zero, so nothing lands during reset.
  initial
  begin
    wr    = 1'b0;
    rd    = 1'b0;
    addr  = 8'h00;
    wdata = 8'h00;
  end

  // One write, held over exactly one rising edge.
  // Idle lines are turned over so a stale value never looks valid.
  task automatic put(input logic [7:0] a, input logic [7:0] d);
    if (a === `REG_OP_CTRL && d[2:1] === 2'b10)
    begin
      return;  // A real host never sends the reserved mode code.
    end
    @(posedge clk);
    #1;
    wr    = 1'b1;
    addr  = a;
    wdata = d;
    @(posedge clk);
    #1;
    wr    = 1'b0;
    addr  = ~addr;
    wdata = ~wdata;
  endtask : put

  // One read; the answer is taken when the valid pulse shows, within a bound.
  task automatic get(input logic [7:0] a, output logic [7:0] d, output bit ok);
    int i;
    @(posedge clk);
    #1;
    rd   = 1'b1;
    addr = a;
    @(posedge clk);
    #1;
    rd   = 1'b0;
    addr = ~addr;
    ok   = 1'b0;
    d    = 8'h00;
    for (i = 0; i < 4 && !ok; i++)
    begin
      if (rvalid === 1'b1)
      begin
        ok = 1'b1;
        d  = rdata;
      end
      else
      begin
        @(posedge clk);
        #1;
      end
    end
  endtask : get

  // Full reset the host way: suspend, then back up to sleep.
  task automatic cycle_power();
    put(`REG_PWR_CTRL, 8'h00);
    put(`REG_PWR_CTRL, 8'h01);
  endtask : cycle_power
endmodule : host_model

/* File: verif/tb_top.sv */
// Top-level bench: clock, reset, bank, host model and register scenarios.
`timescale 1ns/1ns
`include "mag_cfg.svh"
module tb_top;
  import mag_pkg::*;
  localparam int SRST_N = 4;  // Short soft reset keeps the run brief.
  logic                 ref_clk;   // 250 MHz clock.
  logic                 nrst;      // Reset, active low.
  logic [7:0]           live;      // Live interrupt conditions.
  logic                 wr;        // Write strobe.
  logic                 rd;        // Read strobe.
  logic [7:0]           addr;      // Register address.
  logic [7:0]           wdata;     // Write data.
  logic [7:0]           rdata;     // Read data.
  logic                 rvalid;    // Read valid.
  logic                 int_out;   // Interrupt pin.
  logic                 tws;       // Three-wire select.
  logic                 susp;      // Suspend indication.
  logic                 busy;      // Soft reset running.
  opmode_e              op_mode;   // Operation mode.
  measurement_rate_hz_e rate;      // Output rate code.
  logic [1:0]           adv;       // Advanced self-test.
  logic                 nst;       // Normal self-test.
  logic [1:0]           modes [3]; // Legal mode codes only.
  logic [7:0]           v;         // Operation register pattern.
  int                   fail_count; // Mismatches.
  int                   n_tests;    // Comparisons.

  mode_status_regs #(.SRST_CYCLES(SRST_N)) dut_u (
    .REF_CLK(ref_clk), .NRST(nrst), .REG_WR(wr), .REG_RD(rd), .REG_ADDR(addr),
    .REG_WDATA(wdata), .EVT_LIVE(live), .REG_RDATA(rdata), .REG_RVALID(rvalid),
    .INT_OUT(int_out), .THREE_WIRE_SELECT(tws), .SUSPEND(susp), .SRST_BUSY(busy),
    .OP_MODE(op_mode), .MEASUREMENT_RATE_HZ(rate), .ADVANCED_SELFTEST_FIELD(adv),
    .NORMAL_SELFTEST(nst));

  host_model host_u (.clk(ref_clk), .wr(wr), .rd(rd), .addr(addr), .wdata(wdata),
    .rdata(rdata), .rvalid(rvalid));

  // Clock at 4 ns period.
  initial
  begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end

  // Compares one value and counts the outcome.
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp, input string what);
    n_tests++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  // Prints the counts and the verdict, then stops the run.
  task automatic test_done();
    $display("checks %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0)
    begin
      $display("DONE - PASS");
    end
    else
    begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : test_done

  // Reads a register and compares; a missing answer ends the run.
  task automatic rdc(input logic [7:0] a, input logic [7:0] exp, input string what);
    logic [7:0] d;
    bit         ok;
    host_u.get(a, d, ok);
    if (!ok)
    begin
      fail_count++;
      test_done();
    end
    chk(d, exp, what);
  endtask : rdc

  // Waits n edges, then steps off the edge by the stimulus delay.
  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask : cyc

  // Main sequence.
  initial
  begin
    fail_count = 0;
    n_tests    = 0;
    nrst       = 1'b0;
    live       = 8'h00;
    modes      = '{2'b00, 2'b01, 2'b11};
    cyc(4);
    nrst = 1'b1;
    chk({4'h0, susp, busy, tws, int_out}, 8'h08, "reset pins");
    chk({6'h0, op_mode}, {6'h0, OPM_SLEEP}, "reset mode");
    // Suspended: power control is still reachable, the rest is held.
    rdc(`REG_PWR_CTRL, 8'h00, "pwr in suspend");
    rdc(`REG_IRQ_FLAGS, 8'h00, "flags in suspend");
    host_u.put(`REG_OP_CTRL, 8'h00);
    rdc(`REG_OP_CTRL, 8'h00, "op in suspend");
    // Fixed-zero bits drop; wake and three-wire take effect.
    host_u.put(`REG_PWR_CTRL, 8'h7d);
    chk({6'h0, susp, tws}, 8'h01, "wake pins");
    rdc(`REG_PWR_CTRL, 8'h05, "pwr fixed bits");
    rdc(`REG_OP_CTRL, `OP_DEFAULT, "op default");
    // Every rate code, legal mode codes and both self-test controls.
    for (int i = 0; i < 8; i++)
    begin
      v = {i[1:0], i[2:0], modes[i % 3], i[0]};
      host_u.put(`REG_OP_CTRL, v);
      chk({adv, rate, op_mode, nst}, v, "op fields");
      rdc(`REG_OP_CTRL, v, "op readback");
    end
    host_u.cycle_power();
    rdc(`REG_OP_CTRL, `OP_DEFAULT, "op after power cycle");
    // One trigger bit alone must not start a soft reset.
    host_u.put(`REG_OP_CTRL, 8'h3a);
    host_u.put(`REG_PWR_CTRL, 8'h81);
    chk({7'h0, busy}, 8'h00, "busy upper only");
    host_u.put(`REG_PWR_CTRL, 8'h03);
    chk({7'h0, busy}, 8'h00, "busy lower only");
    rdc(`REG_PWR_CTRL, 8'h01, "pwr no trigger");
    host_u.put(`REG_PWR_CTRL, 8'h87);
    chk({7'h0, busy}, 8'h01, "busy both");
    rdc(`REG_PWR_CTRL, 8'h87, "pwr during reset");
    for (int i = 0; i < 20 && busy !== 1'b0; i++)
    begin
      cyc(1);
    end
    if (busy !== 1'b0)
    begin
      fail_count++;
      test_done();
    end
    chk({6'h0, op_mode}, {6'h0, OPM_SLEEP}, "mode after reset");
    rdc(`REG_OP_CTRL, `OP_DEFAULT, "op after reset");
    rdc(`REG_PWR_CTRL, 8'h05, "pwr kept, triggers clear");
    rdc(`REG_IRQ_EN, `IRQ_EN_DEFAULT, "irq enables after reset");
    // A soft reset request in suspend is ignored.
    host_u.put(`REG_PWR_CTRL, 8'h00);
    host_u.put(`REG_PWR_CTRL, 8'h82);
    chk({6'h0, susp, busy}, 8'h02, "suspend ignores reset");
    rdc(`REG_PWR_CTRL, 8'h00, "pwr after ignored reset");
    host_u.put(`REG_PWR_CTRL, 8'h01);
    // Flags: defaults mask axes and overrun, latched mode holds until read.
    live = 8'hff;
    cyc(2);
    rdc(`REG_IRQ_FLAGS, 8'h40, "flags default mask");
    host_u.put(`REG_IRQ_EN, 8'h80);
    cyc(2);
    live = 8'h00;
    cyc(2);
    rdc(`REG_IRQ_FLAGS, 8'hff, "latched flags");
    rdc(`REG_IRQ_FLAGS, 8'h00, "flags cleared by read");
    // Non-latched, pin enabled, overrun masked again.
    host_u.put(`REG_IRQ_EN, 8'h00);
    host_u.put(`REG_IRQ_PIN, 8'h45);
    live = 8'h96;
    cyc(2);
    chk({7'h0, int_out}, 8'h01, "pin active high");
    rdc(`REG_IRQ_FLAGS, 8'h16, "overrun masked");
    live = 8'h00;
    cyc(3);
    chk({7'h0, int_out}, 8'h00, "pin follows live");
    rdc(`REG_IRQ_FLAGS, 8'h00, "live flags drop");
    host_u.put(`REG_IRQ_PIN, 8'h44);
    cyc(2);
    chk({7'h0, int_out}, 8'h01, "pin idle active low");
    // Unmapped place reads zero and ignores writes.
    host_u.put(8'h50, 8'ha5);
    rdc(8'h50, 8'h00, "unmapped");
    test_done();
  end
endmodule : tb_top
